//--- rtl/iers_pkg.sv
// Package: constants, types and register map of the idle exit and reset status block
package iers_pkg;

    // Register byte offsets
    localparam logic [7:0] RESET_CAUSE_STATUS_OFS = 8'h00;
    localparam logic [7:0] CONTROL_OFS            = 8'h04;
    localparam logic [7:0] MODE_STATUS_OFS        = 8'h08;

    // Reset cause status field positions
    localparam int IRQ_PRIO_BIT   = 7;
    localparam int CFG_MISM_BIT   = 5;
    localparam int RST_INSTR_BIT  = 4;
    localparam int WDT_EXP_BIT    = 3;
    localparam int SLEEP_ENT_BIT  = 2;
    localparam int POWERON_BIT    = 1;
    localparam int BROWNOUT_BIT   = 0;
    // Value after power-on: priority off, flags 1 1 1 1 0 0
    localparam logic [7:0] RESET_CAUSE_POR_VAL = 8'h3C;
    // Software may write bits 7,5,4,1,0; bits 3,2 read only, bit 6 absent
    localparam logic [7:0] RESET_CAUSE_WR_MASK = 8'hB3;

    // Control register field positions
    localparam int CTL_IDLE_BIT   = 0;
    localparam int CTL_SRC_LSB    = 1;
    localparam int CTL_SECEN_BIT  = 3;
    localparam int CTL_GIE_BIT    = 4;
    localparam logic [4:0] CONTROL_RST_VAL = 5'h00;

    // Clock source select encodings
    localparam logic [1:0] SRC_SEL_SEC = 2'h1;
    localparam logic [1:0] SRC_SEL_PRI = 2'h2;

    // Default counts in device clock cycles, and the number of interrupt sources
    localparam int CPU_WAKE_CYCLES_DEF = 4;
    localparam int PIN_FILTER_CYCLES_DEF = 8;
    localparam int IRQ_SOURCES_DEF = 8;

    typedef enum logic [1:0] {CLK_RC, CLK_SEC, CLK_PRI} iers_clk_src_t;

    typedef enum logic [3:0] {
        CAUSE_POWERON, CAUSE_PIN_RUN, CAUSE_PIN_LOWPWR, CAUSE_WATCHDOG,
        CAUSE_CFG_MISMATCH, CAUSE_BROWNOUT, CAUSE_RESET_INSTR,
        CAUSE_STACK_FULL, CAUSE_STACK_UNDER
    } iers_cause_t;

    // Instruction strobes from the core, one cycle each
    typedef struct packed {
        logic sleep;
        logic wdt_clear;
        logic reset_instr;
    } iers_core_ev_t;

    // Reset-producing events from other on-chip monitors, one cycle each
    typedef struct packed {
        logic brownout;
        logic cfg_mismatch;
        logic stack_full;
        logic stack_under;
    } iers_rst_ev_t;

    // Clock steering toward the clock sources
    typedef struct packed {
        logic          cpu_clk_en;
        logic          periph_clk_en;
        iers_clk_src_t periph_src;
        logic          primary_osc_en;
        logic          internal_rc_osc_en;
        logic          ost_start;
    } iers_clk_ctl_t;

endpackage : iers_pkg

//--- rtl/iers_core.sv
// Idle mode control, wake sequencing and reset cause tracking behind an AHB-Lite slave
`timescale 1ns/1ps
`default_nettype none
module iers_core
    import iers_pkg::*;
#(
    parameter int CPU_WAKE_CYCLES   = CPU_WAKE_CYCLES_DEF,
    parameter int PIN_FILTER_CYCLES = PIN_FILTER_CYCLES_DEF,
    parameter int IRQ_SOURCES       = IRQ_SOURCES_DEF
) (
    // Clock and power-on reset
    input  wire logic                   hclk,
    input  wire logic                   hresetn,
    // AHB-Lite slave
    input  wire logic                   hsel,
    input  wire logic [31:0]            haddr,
    input  wire logic [1:0]             htrans,
    input  wire logic                   hwrite,
    input  wire logic [2:0]             hsize,
    input  wire logic [31:0]            hwdata,
    input  wire logic                   hready,
    output logic                        hreadyout,
    output logic                        hresp,
    output logic [31:0]                 hrdata,
    // Core and interrupt side
    input  wire iers_core_ev_t          core_ev,
    input  wire logic [IRQ_SOURCES-1:0] irq_flags,
    input  wire logic [IRQ_SOURCES-1:0] irq_enables,
    output logic                        cpu_resume,
    output logic                        branch_to_vector,
    // Watchdog and monitors
    input  wire logic                   wdt_expire,
    input  wire logic                   wdt_enable,
    input  wire logic                   fscm_enable,
    input  wire logic                   clock_lost,
    output logic                        wdt_counter_clear,
    // Clock sources
    input  wire logic                   sec_osc_running,
    input  wire logic                   primary_ready,
    input  wire logic                   external_clock_mode,
    output iers_clk_ctl_t               clk_ctl,
    output logic                        primary_clock_status,
    output logic                        secondary_clock_active,
    // Reset sources and outcome
    input  wire iers_rst_ev_t           rst_ev,
    input  wire logic                   regulator_enable,
    input  wire logic                   external_reset_pin_n_i,
    output logic                        external_reset_pin_n_o,
    output logic                        external_reset_pin_n_oe,
    output logic                        device_reset,
    output iers_cause_t                 last_cause
);

    typedef enum logic [2:0] {ST_RUN, ST_SLEEP, ST_IDLE, ST_OST, ST_WAKE} iers_state_t;

    localparam int WCW = $clog2(CPU_WAKE_CYCLES + 1);
    localparam int FCW = $clog2(PIN_FILTER_CYCLES + 1);
    localparam logic [WCW-1:0] WAKE_LAST = WCW'(CPU_WAKE_CYCLES - 1);
    localparam logic [FCW-1:0] FILT_LAST = FCW'(PIN_FILTER_CYCLES);

    iers_state_t      state_reg, state_next;
    iers_clk_src_t    src_reg, src_next;
    logic [7:0]       rcause_reg, rcause_next;
    logic [4:0]       ctl_reg;
    logic [WCW-1:0]   wake_cnt_reg;
    logic [FCW-1:0]   filt_cnt_reg;
    logic             pin_reset_reg;
    logic             irq_woke_reg;
    logic             reset_pulse_reg;
    logic             resume_reg;
    logic             branch_reg;
    iers_cause_t      cause_reg;
    logic             wr_pend_reg;
    logic [7:0]       wr_addr_reg;
    logic [31:0]      rdata_reg;

    // Control field views
    wire              idle_select         = ctl_reg[CTL_IDLE_BIT];
    wire logic [1:0]  clock_source_select = ctl_reg[CTL_SRC_LSB +: 2];
    wire              secondary_osc_enable = ctl_reg[CTL_SECEN_BIT];
    wire              global_irq_enable   = ctl_reg[CTL_GIE_BIT];

    // Bus decode
    wire              bus_req   = hsel & hready & htrans[1];
    wire              bus_wr    = bus_req & hwrite;
    wire              bus_rd    = bus_req & ~hwrite;
    wire              wr_rcause = wr_pend_reg & (wr_addr_reg == RESET_CAUSE_STATUS_OFS);
    wire              wr_ctl    = wr_pend_reg & (wr_addr_reg == CONTROL_OFS);

    // Wake and instruction decode
    wire              low_power  = (state_reg == ST_SLEEP) | (state_reg == ST_IDLE);
    wire              irq_wake   = |(irq_flags & irq_enables);
    wire              wdt_wake   = wdt_expire & low_power;
    wire              wdt_reset  = wdt_expire & ~low_power;
    wire              sec_sel    = (clock_source_select == SRC_SEL_SEC);
    wire              pri_sel    = (clock_source_select == SRC_SEL_PRI);
    wire              in_run     = (state_reg == ST_RUN);
    // Secondary idle entry refused when its oscillator is off
    wire              sleep_ok   = core_ev.sleep & in_run
                                   & ~(idle_select & sec_sel & ~secondary_osc_enable);
    wire              ost_needed = ~external_clock_mode;

    // Filtered reset pin level; a short low pulse never reaches the counter end
    wire              pin_assert = (filt_cnt_reg == FILT_LAST);
    wire              pin_event  = pin_assert & ~pin_reset_reg;

    // Any reset event; the cause block below picks the cause by its own priority, pin first
    wire              any_reset  = pin_event | wdt_reset | core_ev.reset_instr
                                   | rst_ev.brownout | rst_ev.cfg_mismatch
                                   | rst_ev.stack_full | rst_ev.stack_under;

    // Pin is input only: internal resets, watchdog included, never drive it
    assign external_reset_pin_n_o  = 1'b1;
    assign external_reset_pin_n_oe = 1'b0;

    // Reset pin noise filter
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            filt_cnt_reg  <= '0;
            pin_reset_reg <= 1'b0;
        end else begin
            if (external_reset_pin_n_i) begin
                filt_cnt_reg <= '0;
            end else if (!pin_assert) begin
                filt_cnt_reg <= filt_cnt_reg + FCW'(1);
            end
            pin_reset_reg <= pin_assert;
        end
    end

    // Mode sequencer: entry, wake, start-up wait and wake delay
    always_comb begin
        state_next = state_reg;
        src_next   = src_reg;
        case (state_reg)
            ST_RUN: begin
                if (sleep_ok && idle_select) begin
                    state_next = ST_IDLE;
                    if (sec_sel) begin
                        src_next = CLK_SEC;
                    end else if (pri_sel) begin
                        src_next = CLK_PRI;
                    end else begin
                        src_next = CLK_RC;
                    end
                end else if (sleep_ok) begin
                    state_next = ST_SLEEP;
                end else if (sec_sel && secondary_osc_enable) begin
                    src_next = CLK_SEC;
                end else if (pri_sel && (primary_ready || external_clock_mode)) begin
                    src_next = CLK_PRI;
                end else if (!sec_sel && !pri_sel) begin
                    src_next = CLK_RC;
                end
            end
            ST_IDLE: begin
                // Idle keeps its source; only the delay stands before the CPU
                if (irq_wake || wdt_wake) begin
                    state_next = ST_WAKE;
                end
            end
            ST_SLEEP: begin
                if (irq_wake || wdt_wake) begin
                    if (sec_sel && secondary_osc_enable) begin
                        src_next   = CLK_SEC;
                        state_next = ST_WAKE;
                    end else if (pri_sel) begin
                        src_next   = CLK_PRI;
                        state_next = ost_needed ? ST_OST : ST_WAKE;
                    end else begin
                        src_next   = CLK_RC;
                        state_next = ST_WAKE;
                    end
                end
            end
            ST_OST: begin
                if (primary_ready) begin
                    state_next = ST_WAKE;
                end
            end
            ST_WAKE: begin
                if (wake_cnt_reg == WAKE_LAST) begin
                    state_next = ST_RUN;
                end
            end
            default: begin
                state_next = ST_RUN;
            end
        endcase
        // A reset wins over everything and lands on the internal oscillator
        if (any_reset) begin
            state_next = ST_RUN;
            src_next   = CLK_RC;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg <= ST_RUN;
            src_reg   <= CLK_RC;
        end else begin
            state_reg <= state_next;
            src_reg   <= src_next;
        end
    end

    // Wake delay counter, fixed length after every wake event
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wake_cnt_reg <= '0;
        end else if (state_reg != ST_WAKE) begin
            wake_cnt_reg <= '0;
        end else begin
            wake_cnt_reg <= wake_cnt_reg + WCW'(1);
        end
    end

    // Resume strobe and vector decision; the interrupt cause is remembered
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_woke_reg <= 1'b0;
            resume_reg   <= 1'b0;
            branch_reg   <= 1'b0;
        end else begin
            if (low_power && (irq_wake || wdt_wake)) begin
                irq_woke_reg <= irq_wake;
            end
            resume_reg <= (state_reg == ST_WAKE) && (state_next == ST_RUN);
            branch_reg <= (state_reg == ST_WAKE) && (state_next == ST_RUN)
                          && irq_woke_reg && global_irq_enable;
        end
    end

    assign cpu_resume       = resume_reg;
    assign branch_to_vector = branch_reg;

    // Watchdog clear on sleep, clear instruction or lost clock under the monitor
    assign wdt_counter_clear = core_ev.sleep | core_ev.wdt_clear
                               | (clock_lost & fscm_enable);

    // Clock steering
    always_comb begin
        clk_ctl.cpu_clk_en     = (state_reg == ST_RUN);
        clk_ctl.periph_clk_en  = (state_reg != ST_SLEEP) && (state_reg != ST_OST)
                                 && !((src_reg == CLK_SEC) && !sec_osc_running);
        clk_ctl.periph_src     = src_reg;
        clk_ctl.primary_osc_en = ((src_reg == CLK_PRI) && (state_reg != ST_SLEEP))
                                 || (in_run && pri_sel);
        clk_ctl.internal_rc_osc_en       = ((src_reg == CLK_RC) && (state_reg != ST_SLEEP))
                                 || wdt_enable || fscm_enable;
        clk_ctl.ost_start      = (state_reg == ST_SLEEP) && (state_next == ST_OST);
    end

    // Clock source status bits
    assign primary_clock_status   = (src_reg == CLK_PRI) && (state_reg != ST_SLEEP)
                                    && (state_reg != ST_OST);
    assign secondary_clock_active = (src_reg == CLK_SEC) && (state_reg != ST_SLEEP);

    // Reset status flags: events override a software write in the same cycle
    always_comb begin
        rcause_next = rcause_reg;
        if (wr_rcause) begin
            rcause_next = (rcause_reg & ~RESET_CAUSE_WR_MASK)
                          | (hwdata[7:0] & RESET_CAUSE_WR_MASK);
        end
        if (core_ev.sleep) begin
            rcause_next[WDT_EXP_BIT]   = 1'b1;
            rcause_next[SLEEP_ENT_BIT] = 1'b0;
        end
        if (core_ev.wdt_clear) begin
            rcause_next[WDT_EXP_BIT]   = 1'b1;
            rcause_next[SLEEP_ENT_BIT] = 1'b1;
        end
        if (wdt_expire) begin
            rcause_next[WDT_EXP_BIT] = 1'b0;
        end
        if (pin_event) begin
            rcause_next[WDT_EXP_BIT] = low_power | ~in_run | (src_reg != CLK_PRI)
                                       ? 1'b1 : rcause_reg[WDT_EXP_BIT];
            if (low_power) begin
                rcause_next[SLEEP_ENT_BIT] = 1'b0;
            end
        end
        if (core_ev.reset_instr) begin
            rcause_next[RST_INSTR_BIT] = 1'b0;
        end
        if (rst_ev.cfg_mismatch) begin
            rcause_next[CFG_MISM_BIT] = 1'b0;
        end
        if (rst_ev.brownout) begin
            rcause_next[CFG_MISM_BIT]  = 1'b1;
            rcause_next[RST_INSTR_BIT] = 1'b1;
            rcause_next[WDT_EXP_BIT]   = 1'b1;
            rcause_next[SLEEP_ENT_BIT] = 1'b1;
            rcause_next[BROWNOUT_BIT]  = 1'b0;
        end
        rcause_next[6] = 1'b0;
    end

    // Power-on reset sets the flags to their power-up pattern
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rcause_reg <= RESET_CAUSE_POR_VAL;
        end else begin
            rcause_reg <= rcause_next;
        end
    end

    // Reset outcome and cause code
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            reset_pulse_reg <= 1'b0;
            cause_reg       <= CAUSE_POWERON;
        end else begin
            reset_pulse_reg <= any_reset;
            if (pin_event) begin
                cause_reg <= low_power ? CAUSE_PIN_LOWPWR : CAUSE_PIN_RUN;
            end else if (wdt_reset) begin
                cause_reg <= CAUSE_WATCHDOG;
            end else if (rst_ev.cfg_mismatch) begin
                cause_reg <= CAUSE_CFG_MISMATCH;
            end else if (rst_ev.brownout) begin
                cause_reg <= CAUSE_BROWNOUT;
            end else if (core_ev.reset_instr) begin
                cause_reg <= CAUSE_RESET_INSTR;
            end else if (rst_ev.stack_full) begin
                cause_reg <= CAUSE_STACK_FULL;
            end else if (rst_ev.stack_under) begin
                cause_reg <= CAUSE_STACK_UNDER;
            end
        end
    end

    // The pin holds the device in reset as long as it stays low
    assign device_reset = reset_pulse_reg | pin_reset_reg;
    assign last_cause   = cause_reg;

    // Control register: mode bits are never touched by a wake
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctl_reg <= CONTROL_RST_VAL;
        end else if (wr_ctl) begin
            ctl_reg <= hwdata[4:0];
        end
    end

    // Bus address phase capture; zero wait states so no stall is ever needed
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
        end else begin
            wr_pend_reg <= bus_wr && (haddr[31:8] == 24'h000000);
            wr_addr_reg <= haddr[7:0];
        end
    end

    // Read mux: brown-out flag forced low while the regulator is off
    wire [7:0] rcause_view = {rcause_reg[7:1],
                              rcause_reg[BROWNOUT_BIT] & regulator_enable};
    wire [31:0] mode_view  = {20'h00000, cause_reg, 1'b0, state_reg,
                              primary_clock_status, secondary_clock_active,
                              src_reg};
    wire [31:0] rd_mux     =
        (haddr == {24'h000000, RESET_CAUSE_STATUS_OFS}) ? {24'h000000, rcause_view} :
        (haddr == {24'h000000, CONTROL_OFS})            ? {27'h0000000, ctl_reg}    :
        (haddr == {24'h000000, MODE_STATUS_OFS})        ? mode_view                 :
                                                          32'h00000000;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rdata_reg <= 32'h00000000;
        end else if (bus_rd) begin
            rdata_reg <= rd_mux;
        end
    end

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = rdata_reg;

    // Unused bus inputs kept visible to avoid silent drop warnings
    wire unused_ok = &{1'b0, hsize, htrans[0]};

endmodule : iers_core
`default_nettype wire

//--- verification/iers_monitor.sv
// Checker for the idle exit and reset status block ports
`timescale 1ns/1ps
`default_nettype none
module iers_monitor
    import iers_pkg::*;
(
    // Clock and reset
    input wire logic          hclk,
    input wire logic          hresetn,
    // Observed ports
    input wire iers_core_ev_t core_ev,
    input wire logic          clock_lost,
    input wire logic          fscm_enable,
    input wire logic          wdt_counter_clear,
    input wire logic          sec_osc_running,
    input wire iers_clk_ctl_t clk_ctl,
    input wire logic          primary_clock_status,
    input wire logic          secondary_clock_active,
    input wire logic          cpu_resume,
    input wire logic          branch_to_vector,
    input wire logic          external_reset_pin_n_oe
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Clear pulse has no latency, so it is checked in the cause cycle
    a_clear_on_sleep: assert property (core_ev.sleep |-> wdt_counter_clear)
        else $error("no clear on sleep");
    a_clear_on_loss: assert property (clock_lost && fscm_enable |-> wdt_counter_clear)
        else $error("no clear on clock loss");
    a_pin_undriven: assert property (!external_reset_pin_n_oe)
        else $error("reset pin driven");
    a_branch_resume: assert property (branch_to_vector |-> cpu_resume)
        else $error("branch without resume");
    // Resume falls on the first clocked cycle after the wake delay
    a_resume_clocked: assert property (
        cpu_resume |-> clk_ctl.cpu_clk_en && !$past(clk_ctl.cpu_clk_en))
        else $error("resume not on first clocked cycle");
    a_resume_single: assert property (cpu_resume |=> !cpu_resume)
        else $error("resume too long");
    a_primary_exact: assert property (primary_clock_status |-> clk_ctl.primary_osc_en)
        else $error("primary status wrong");
    a_sec_exclusive: assert property (secondary_clock_active |-> !primary_clock_status)
        else $error("both sources active");
    a_periph_waits: assert property (clk_ctl.periph_clk_en && clk_ctl.periph_src == CLK_SEC
        |-> sec_osc_running)
        else $error("peripheral clock early");
    // Main scenarios reached
    c_branch: cover property (branch_to_vector);
    c_secondary: cover property (secondary_clock_active && cpu_resume);
    c_primary: cover property (primary_clock_status);
endmodule : iers_monitor
bind iers_core iers_monitor iers_monitor_inst (.hclk, .hresetn, .core_ev, .clock_lost,
    .fscm_enable, .wdt_counter_clear, .sec_osc_running, .clk_ctl, .primary_clock_status,
    .secondary_clock_active, .cpu_resume, .branch_to_vector, .external_reset_pin_n_oe);
`default_nettype wire

//--- verification/iers_osc_model.sv
// Oscillator sources facing the block, with start-up time
`timescale 1ns/1ps
`default_nettype none
module iers_osc_model
    import iers_pkg::*;
#(parameter int START_CYCLES = 3) (
    // Clock and reset
    input wire logic          hclk,
    input wire logic          hresetn,
    // Power to the crystals
    input wire logic          sec_power,
    input wire iers_clk_ctl_t clk_ctl,
    // Ready levels back to the block
    output logic              sec_osc_running,
    output logic              primary_ready
);
    int sec_cnt;
    int pri_cnt;
    // Each crystal reports running only START_CYCLES after power, so waiting logic gets exercised
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sec_cnt <= 0;
            pri_cnt <= 0;
        end else begin
            sec_cnt <= sec_power ? sec_cnt + int'(sec_cnt < START_CYCLES) : 0;
            pri_cnt <= clk_ctl.primary_osc_en ? pri_cnt + int'(pri_cnt < START_CYCLES) : 0;
        end
    end
    assign sec_osc_running = (sec_cnt == START_CYCLES);
    assign primary_ready   = (pri_cnt == START_CYCLES);
endmodule : iers_osc_model
`default_nettype wire

//--- verification/iers_core_test.sv
// Testbench of the idle exit and reset status block
`timescale 1ns/1ps
`default_nettype none
module iers_core_test
    import iers_pkg::*;
;
    localparam int WK = 2;
    localparam int PF = 3;
    localparam iers_rst_ev_t RV [6] = '{4'h0, 4'h0, 4'h4, 4'h8, 4'h2, 4'h1};
    localparam iers_cause_t CS [6] = '{CAUSE_WATCHDOG, CAUSE_RESET_INSTR,
        CAUSE_CFG_MISMATCH, CAUSE_BROWNOUT, CAUSE_STACK_FULL, CAUSE_STACK_UNDER};
    localparam logic [7:0] BM [6] = '{8'h08, 8'h10, 8'h20, 8'h01, 8'h00, 8'h00};
    localparam logic [7:0] KP [6] = '{8'h32, 8'h23, 8'h13, 8'h3E, 8'h33, 8'h33};
    logic hclk = 0, hresetn = 0, hwrite = 0, wdt_expire = 0, clock_lost = 0;
    logic fscm_enable = 1, sec_power = 0, regulator_enable = 1, pin_n = 1, ext_clk = 0;
    logic hreadyout, cpu_resume, branch_to_vector, primary_clock_status;
    logic device_reset, sec_act, sec_run, prim_rdy;
    logic [1:0] htrans = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
    logic [7:0] irq_flags = 0, irq_enables = 8'hFF;
    iers_core_ev_t core_ev = '0;
    iers_rst_ev_t rst_ev = '0;
    iers_clk_ctl_t clk_ctl;
    iers_cause_t last_cause;
    int n_errors = 0, cmp_count = 0, cyc = 0;
    iers_core #(.CPU_WAKE_CYCLES(WK), .PIN_FILTER_CYCLES(PF)) iers_core_inst (.hclk, .hresetn,
        .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout),
        .hreadyout, .hresp(), .hrdata, .core_ev, .irq_flags, .irq_enables, .cpu_resume,
        .branch_to_vector, .wdt_expire, .wdt_enable(1'b1), .fscm_enable, .clock_lost,
        .wdt_counter_clear(), .sec_osc_running(sec_run), .primary_ready(prim_rdy),
        .external_clock_mode(ext_clk), .clk_ctl, .primary_clock_status,
        .secondary_clock_active(sec_act), .rst_ev, .regulator_enable,
        .external_reset_pin_n_i(pin_n), .external_reset_pin_n_o(),
        .external_reset_pin_n_oe(), .device_reset, .last_cause);
    iers_osc_model iers_osc_model_inst (.hclk, .hresetn, .sec_power, .clk_ctl,
        .sec_osc_running(sec_run), .primary_ready(prim_rdy));
    always #20 hclk = ~hclk;
    // Hang guard, far above the roughly 150 cycles needed
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 3000) begin
            n_errors++;
            end_of_test;
        end
    end
    task automatic chk(input string n, input logic [31:0] g, e);
        cmp_count++;
        if (g !== e) begin
            n_errors++;
            $display("[ERR] %s exp %h got %h", n, e, g);
        end
    endtask : chk
    // Single AHB-Lite transfer, read data left in rd
    task automatic bus(input logic wr, input logic [31:0] a, d);
        htrans <= 2'h2; haddr <= a; hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0; hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : bus
    task automatic cev(input iers_core_ev_t v);
        core_ev <= v;
        @(posedge hclk);
        core_ev <= '0;
    endtask : cev
    task automatic wake(input logic [7:0] f, input logic br);
        irq_flags <= f;
        repeat (WK + 1) @(posedge hclk);
        chk("early", {31'h0, cpu_resume}, 0);
        @(posedge hclk);
        chk("resume", {31'h0, cpu_resume}, 1);
        chk("branch", {31'h0, branch_to_vector}, {31'h0, br});
        irq_flags <= 8'h00;
    endtask : wake
    task automatic wres;
        for (int k = 0; k < 60 && cpu_resume !== 1'b1; k++) @(posedge hclk);
        chk("resume", {31'h0, cpu_resume}, 1);
    endtask : wres
    task end_of_test;
        $display("errors %0d compares %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : end_of_test
    initial begin
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        bus(0, 0, 0); chk("por", rd, 32'h3C);
        bus(1, 0, 32'hFF); bus(0, 0, 0); chk("rw", rd, 32'hBF);
        bus(0, 32'h10, 0); chk("unmapped", rd, 0);
        bus(1, 4, 32'h03); cev(3'h4); bus(0, 8, 0); chk("refused", rd & 32'h70, 0);
        // Crystal powered with the sleep, so peripherals must wait for it
        bus(1, 4, 32'h0B); sec_power <= 1'b1; cev(3'h4); wake(8'h01, 0);
        chk("sec", {31'h0, sec_act}, 1);
        bus(0, 4, 0); chk("ctl", rd, 32'h0B);
        bus(0, 0, 0); chk("sleep", rd, 32'hBB);
        cev(3'h2); bus(0, 0, 0); chk("clear", rd, 32'hBF);
        bus(1, 4, 32'h11); cev(3'h4); wake(8'h80, 1);
        chk("rc", {29'h0, clk_ctl.periph_src, clk_ctl.internal_rc_osc_en}, 1);
        bus(1, 4, 0); cev(3'h4); wdt_expire <= 1; @(posedge hclk); wdt_expire <= 0; wres;
        bus(0, 0, 0); chk("wdt", rd, 32'hB3);
        clock_lost <= 1; @(posedge hclk); clock_lost <= 0;
        bus(1, 4, 32'h04); cev(3'h4); irq_flags <= 1; wres; irq_flags <= 0;
        chk("pri", {31'h0, primary_clock_status}, 1);
        // External clock skips the start-up wait, so only the wake delay stands
        ext_clk <= 1; cev(3'h4); wake(8'h01, 0); ext_clk <= 0;
        for (int i = 0; i < 6; i++) begin
            bus(1, 0, 32'hFF);
            rst_ev <= RV[i]; wdt_expire <= (i == 0); core_ev <= (i == 1) ? 3'h1 : 3'h0;
            @(posedge hclk);
            rst_ev <= '0; wdt_expire <= 0; core_ev <= '0;
            repeat (3) @(posedge hclk);
            chk("cause", {28'h0, last_cause}, {28'h0, CS[i]});
            bus(0, 0, 0); chk("flags", rd & {24'h0, BM[i] | KP[i]}, {24'h0, KP[i]});
        end
        pin_n <= 0; @(posedge hclk); pin_n <= 1; repeat (4) @(posedge hclk);
        chk("glitch", {31'h0, device_reset}, 0);
        pin_n <= 0; repeat (PF + 3) @(posedge hclk);
        chk("pin", {27'h0, device_reset, last_cause}, {27'h0, 1'b1, CAUSE_PIN_RUN});
        pin_n <= 1; repeat (3) @(posedge hclk);
        // Pin held low while asleep is reported as a low-power pin reset
        cev(3'h4); pin_n <= 0; repeat (PF + 3) @(posedge hclk);
        chk("pinlp", {28'h0, last_cause}, {28'h0, CAUSE_PIN_LOWPWR});
        pin_n <= 1; repeat (3) @(posedge hclk);
        regulator_enable <= 0; bus(1, 0, 32'hFF); bus(0, 0, 0);
        chk("regoff", rd & 32'h1, 0);
        hresetn <= 0; @(posedge hclk); hresetn <= 1;
        bus(0, 0, 0); chk("por2", rd, 32'h3C);
        end_of_test;
    end
endmodule : iers_core_test
`default_nettype wire
